// ==== common/irq_pkg.sv ====
// constants, register map and carrier types of the interrupt vectoring block
// assumes one clock domain; the core consumes the command struct each cycle
package irq_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int CORE_N   = 3;
    localparam int PERIPH_N = 8;
    localparam int PC_W     = 15;
    localparam int EVT_W    = 2;
    localparam int ADDR_W   = 6;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_PFLAG1  = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_PFLAG2  = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_PEN1    = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_PEN2    = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_EVT_ST  = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_EVT_MSK = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_SHADOW  = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_STATE   = 6'h20;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTL_GIE_BIT  = 7;
    localparam int CTL_PERIPH_GROUP_IRQ_ENABLE_BIT = 6;
    localparam int CTL_EN_LSB   = 3;
    localparam int CTL_FLAG_LSB = 0;
    localparam int EVT_VEC_BIT  = 0;
    localparam int EVT_RET_BIT  = 1;
    localparam int ST_REQ_BIT   = 2;

    // ------------------------------------------------------------------
    // values
    // ------------------------------------------------------------------
    localparam logic [PC_W-1:0] VECTOR_ADDR = 15'h0004;
    localparam logic [31:0]     UNMAPPED_RD = 32'h0000_0000;

    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_ACCEPT = 2'b01,
        SEQ_VECTOR = 2'b10
    } seq_t;

    typedef struct packed {
        logic [7:0] w;
        logic [7:0] status;
        logic [7:0] bsr;
        logic [7:0] pclath;
    } ctx_t;

    typedef struct packed {
        logic [CORE_N-1:0]   core;
        logic [PERIPH_N-1:0] p1;
        logic [PERIPH_N-1:0] p2;
    } evt_t;

    typedef struct packed {
        logic            flush;
        logic            push;
        logic [PC_W-1:0] push_pc;
        logic            load_vec;
        logic [PC_W-1:0] vec_addr;
        logic            pop;
        logic            restore;
        ctx_t            restore_ctx;
    } core_cmd_t;

    typedef struct packed {
        logic                global_irq_enable;
        logic                periph_group_irq_enable;
        logic [CORE_N-1:0]   core_en;
        logic [CORE_N-1:0]   core_flag;
        logic [PERIPH_N-1:0] pen1;
        logic [PERIPH_N-1:0] pen2;
        logic [PERIPH_N-1:0] pflag1;
        logic [PERIPH_N-1:0] pflag2;
        seq_t                seq;
        logic [PC_W-1:0]     saved_pc;
        ctx_t                shadow;
        logic                ret;
        logic [EVT_W-1:0]    evt_st;
        logic [EVT_W-1:0]    evt_msk;
        logic                ack;
        logic [31:0]         rdata;
        logic [PERIPH_N-1:0] sync1;
        logic [PERIPH_N-1:0] sync2;
        logic [PERIPH_N-1:0] sync3;
    } state_t;

    localparam state_t STATE_RESET = '0;

endpackage

// ==== hdl/core_interrupt_vectoring.sv ====
// interrupt flags, enables and vectoring sequence for an 8-bit core
// assumes the core runs on ref_clk, one instruction cycle per clock, and
// reacts to the command struct in the cycle it is presented
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module core_interrupt_vectoring #(
    parameter int CORE_N   = irq_pkg::CORE_N,
    parameter int PERIPH_N = irq_pkg::PERIPH_N
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    input  wire logic [irq_pkg::ADDR_W-1:0]    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [3:0]                    avs_byteenable,
    input  wire logic [31:0]                   avs_writedata,
    output logic      [31:0]                   avs_readdata,
    output logic                               avs_waitrequest,
    input  wire irq_pkg::evt_t                 evt_in,
    input  wire logic [irq_pkg::PC_W-1:0]      pc_in,
    input  wire irq_pkg::ctx_t                 ctx_in,
    input  wire logic                          core_stall,
    input  wire logic                          return_from_irq_instr,
    output irq_pkg::core_cmd_t                 core_cmd,
    output logic                               irq_pending,
    output logic                               irq_out
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    // the state struct is sized by the package, so widths must agree
    if (CORE_N != irq_pkg::CORE_N) begin : g_core_chk
        $error("CORE_N must equal the package source count");
    end
    if (PERIPH_N != irq_pkg::PERIPH_N) begin : g_per_chk
        $error("PERIPH_N must equal the package peripheral count");
    end

    irq_pkg::state_t s_r;
    irq_pkg::state_t s_nxt;

    logic                bus_wr;
    logic [7:0]          wbyte;
    logic [PERIPH_N-1:0] p2_edge;
    logic                core_hit;
    logic                periph_hit;
    logic                irq_req;
    logic [31:0]         rd_mux;
    logic [irq_pkg::EVT_W-1:0] evt_set;

    // ------------------------------------------------------------------
    // request gating
    // ------------------------------------------------------------------
    assign core_hit   = |(s_r.core_en & s_r.core_flag);
    assign periph_hit = s_r.periph_group_irq_enable &
                        |((s_r.pen1 & s_r.pflag1) |
                          (s_r.pen2 & s_r.pflag2));
    assign irq_req    = s_r.global_irq_enable & (core_hit | periph_hit);
    assign irq_pending = irq_req;

    // asynchronous sources only count once through both sync stages
    assign p2_edge = s_r.sync2 & ~s_r.sync3;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // one wait state: the request is taken on the edge where ack is high
    assign avs_waitrequest = (avs_read | avs_write) & ~s_r.ack;
    assign avs_readdata    = s_r.rdata;
    assign bus_wr = avs_write & s_r.ack & avs_byteenable[0];
    assign wbyte  = avs_writedata[7:0];

    always_comb begin
        rd_mux = irq_pkg::UNMAPPED_RD;
        case (avs_address)
            irq_pkg::OFS_CONTROL: begin
                rd_mux[irq_pkg::CTL_GIE_BIT]  = s_r.global_irq_enable;
                rd_mux[irq_pkg::CTL_PERIPH_GROUP_IRQ_ENABLE_BIT] = s_r.periph_group_irq_enable;
                rd_mux[irq_pkg::CTL_EN_LSB +: CORE_N]   = s_r.core_en;
                rd_mux[irq_pkg::CTL_FLAG_LSB +: CORE_N] = s_r.core_flag;
            end
            irq_pkg::OFS_PFLAG1:  rd_mux[PERIPH_N-1:0] = s_r.pflag1;
            irq_pkg::OFS_PFLAG2:  rd_mux[PERIPH_N-1:0] = s_r.pflag2;
            irq_pkg::OFS_PEN1:    rd_mux[PERIPH_N-1:0] = s_r.pen1;
            irq_pkg::OFS_PEN2:    rd_mux[PERIPH_N-1:0] = s_r.pen2;
            irq_pkg::OFS_EVT_ST:
                rd_mux[irq_pkg::EVT_W-1:0] = s_r.evt_st;
            irq_pkg::OFS_EVT_MSK:
                rd_mux[irq_pkg::EVT_W-1:0] = s_r.evt_msk;
            irq_pkg::OFS_SHADOW:  rd_mux = s_r.shadow;
            irq_pkg::OFS_STATE: begin
                rd_mux[1:0] = s_r.seq;
                rd_mux[irq_pkg::ST_REQ_BIT] = irq_req;
            end
            default: rd_mux = irq_pkg::UNMAPPED_RD;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt   = s_r;
        evt_set = '0;

        s_nxt.ack = (avs_read | avs_write) & ~s_r.ack;
        if (avs_read && !s_r.ack) begin
            s_nxt.rdata = rd_mux;
        end

        // sync1 feeds sync2 only
        s_nxt.sync1 = evt_in.p2;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sync3 = s_r.sync2;
        s_nxt.ret   = 1'b0;

        // software writes first; hardware sets and clears follow so
        // they win in a collision
        if (bus_wr) begin
            case (avs_address)
                irq_pkg::OFS_CONTROL: begin
                    s_nxt.global_irq_enable       = wbyte[irq_pkg::CTL_GIE_BIT];
                    s_nxt.periph_group_irq_enable      = wbyte[irq_pkg::CTL_PERIPH_GROUP_IRQ_ENABLE_BIT];
                    s_nxt.core_en   = wbyte[irq_pkg::CTL_EN_LSB +: CORE_N];
                    s_nxt.core_flag = wbyte[irq_pkg::CTL_FLAG_LSB +: CORE_N];
                end
                irq_pkg::OFS_PFLAG1:  s_nxt.pflag1 = wbyte;
                irq_pkg::OFS_PFLAG2:  s_nxt.pflag2 = wbyte;
                irq_pkg::OFS_PEN1:    s_nxt.pen1   = wbyte;
                irq_pkg::OFS_PEN2:    s_nxt.pen2   = wbyte;
                irq_pkg::OFS_EVT_ST:
                    s_nxt.evt_st = s_r.evt_st &
                                   ~wbyte[irq_pkg::EVT_W-1:0];
                irq_pkg::OFS_EVT_MSK:
                    s_nxt.evt_msk = wbyte[irq_pkg::EVT_W-1:0];
                default: s_nxt.ack = s_nxt.ack;
            endcase
        end

        // flags latch regardless of any enable, and a clear loses to a set
        s_nxt.core_flag = s_nxt.core_flag | evt_in.core;
        s_nxt.pflag1    = s_nxt.pflag1 | evt_in.p1;
        s_nxt.pflag2    = s_nxt.pflag2 | p2_edge;

        case (s_r.seq)
            irq_pkg::SEQ_IDLE: begin
                if (return_from_irq_instr) begin
                    s_nxt.global_irq_enable = 1'b1;
                    s_nxt.ret = 1'b1;
                    evt_set[irq_pkg::EVT_RET_BIT] = 1'b1;
                end else if (irq_req && !core_stall) begin
                    // a stalled two-cycle instruction adds the fourth cycle
                    s_nxt.seq      = irq_pkg::SEQ_ACCEPT;
                    s_nxt.global_irq_enable      = 1'b0;
                    s_nxt.saved_pc = pc_in;
                    s_nxt.shadow   = ctx_in;
                end
            end
            irq_pkg::SEQ_ACCEPT: begin
                s_nxt.global_irq_enable = 1'b0;
                s_nxt.seq = irq_pkg::SEQ_VECTOR;
            end
            irq_pkg::SEQ_VECTOR: begin
                s_nxt.global_irq_enable = 1'b0;
                s_nxt.seq = irq_pkg::SEQ_IDLE;
                evt_set[irq_pkg::EVT_VEC_BIT] = 1'b1;
            end
            default: s_nxt.seq = irq_pkg::SEQ_IDLE;
        endcase

        s_nxt.evt_st = s_nxt.evt_st | evt_set;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= irq_pkg::STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // core commands
    // ------------------------------------------------------------------
    // pending flags after return fire from IDLE as soon as gie is back
    always_comb begin
        core_cmd          = '0;
        core_cmd.flush    = (s_r.seq == irq_pkg::SEQ_ACCEPT);
        core_cmd.push     = (s_r.seq == irq_pkg::SEQ_ACCEPT);
        core_cmd.push_pc  = s_r.saved_pc;
        core_cmd.load_vec = (s_r.seq == irq_pkg::SEQ_VECTOR);
        core_cmd.vec_addr = irq_pkg::VECTOR_ADDR;
        core_cmd.pop      = s_r.ret;
        core_cmd.restore  = s_r.ret;
        core_cmd.restore_ctx = s_r.shadow;
    end

    assign irq_out = |(s_r.evt_st & s_r.evt_msk);

endmodule

// ==== sim/irq_checker.sv ====
// port assertions for the interrupt vectoring block
// assumes one clock domain; bound into every instance of the block
`timescale 1ns/1ps
module irq_checker (
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic               avs_waitrequest,
    input wire logic [14:0]        pc_in,
    input wire logic               core_stall,
    input wire logic               return_from_irq_instr,
    input wire irq_pkg::core_cmd_t core_cmd,
    input wire logic               irq_pending
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_reset_quiet: assert property ($rose(rst_n) |-> !irq_pending)
        else $error("request high right after reset");
    a_accept_next: assert property (irq_pending && !core_stall
        && !return_from_irq_instr |=> core_cmd.flush)
        else $error("request not accepted at once");
    a_flush_cause: assert property (core_cmd.flush |->
        $past(irq_pending) && !$past(core_stall))
        else $error("flush without a request");
    a_accept_order: assert property (core_cmd.flush |->
        core_cmd.push && !irq_pending ##1 core_cmd.load_vec
        && !core_cmd.flush)
        else $error("accept sequence out of order");
    a_vector_addr: assert property (core_cmd.load_vec |->
        $past(core_cmd.push) && core_cmd.vec_addr == irq_pkg::VECTOR_ADDR)
        else $error("vector load without push or wrong address");
    a_push_pc: assert property (core_cmd.push |->
        core_cmd.push_pc == $past(pc_in))
        else $error("pushed pc is not the accept pc");
    a_ret_pop: assert property (return_from_irq_instr
        && !core_cmd.flush && !core_cmd.load_vec |=>
        core_cmd.pop && core_cmd.restore ##1 !core_cmd.pop)
        else $error("return did not pop once");
    a_stall_holds: assert property (irq_pending && core_stall
        |=> !core_cmd.flush)
        else $error("accepted during stall");
    a_req_waits: assert property ($rose(avs_read || avs_write)
        |-> avs_waitrequest)
        else $error("bus answered without wait state");
    a_one_wait: assert property ((avs_read || avs_write)
        && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
endmodule

bind core_interrupt_vectoring irq_checker u_chk (
    .ref_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .pc_in,
    .core_stall, .return_from_irq_instr, .core_cmd, .irq_pending
);

// ==== sim/core_model.sv ====
// core side: program counter, return stack and return pulse
// assumes the command struct is acted on in the cycle it stands
`timescale 1ns/1ps
module core_model (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire irq_pkg::core_cmd_t core_cmd,
    input  wire logic               ret_req,
    output logic [14:0]             pc_in,
    output irq_pkg::ctx_t           ctx_in,
    output logic                    return_from_irq_instr,
    output logic [14:0]             stack_top
);
    // context follows the low pc byte so saves at different pc[7:0] are distinguishable
    assign ctx_in = {pc_in[7:0], 24'h5A3CC3};
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_in <= 15'h0000;
            stack_top <= 15'h0000;
            return_from_irq_instr <= 1'b0;
        end else begin
            return_from_irq_instr <= ret_req;
            if (core_cmd.push)
                stack_top <= core_cmd.push_pc;
            if (core_cmd.load_vec)
                pc_in <= core_cmd.vec_addr;
            else if (core_cmd.pop)
                pc_in <= stack_top;
            else
                pc_in <= pc_in + 15'h0001;
        end
    end
endmodule

// ==== sim/core_interrupt_vectoring_tb.sv ====
// self-checking bench for the interrupt vectoring block
// assumes the core model beside it and the checker bound in
`timescale 1ns/1ps
module core_interrupt_vectoring_tb;
    logic               ref_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic [5:0]         avs_address = 6'h00;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic [31:0]        avs_writedata = 32'h0;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    irq_pkg::evt_t      evt_in = '0;
    logic               core_stall = 1'b0;
    logic               ret_req = 1'b0;
    logic [14:0]        pc_in;
    logic [14:0]        stack_top;
    irq_pkg::ctx_t      ctx_in;
    logic               return_from_irq_instr;
    irq_pkg::core_cmd_t core_cmd;
    logic               irq_pending;
    logic               irq_out;
    logic [31:0]        rd;
    logic [31:0]        ctx_exp;
    int                 failures = 0;
    int                 total_checks = 0;
    int                 n;

    core_interrupt_vectoring u_dut (
        .ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_byteenable(4'hF), .avs_writedata, .avs_readdata,
        .avs_waitrequest, .evt_in, .pc_in, .ctx_in, .core_stall,
        .return_from_irq_instr, .core_cmd, .irq_pending, .irq_out
    );
    core_model u_core (
        .ref_clk, .rst_n, .core_cmd, .ret_req, .pc_in, .ctx_in,
        .return_from_irq_instr, .stack_top
    );

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one idle cycle after each access so strobes never toggle twice
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_read <= !wr;
        avs_write <= wr;
        // no local limit: only the watchdog ends a hung wait
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        check($sformatf("register %h", a), exp, rd);
    endtask

    task automatic ret_pulse();
        ret_req <= 1'b1;
        @(posedge ref_clk);
        ret_req <= 1'b0;
    endtask

    task automatic wait_vec();
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            core_stall <= 1'b0;
        end while (core_cmd.load_vec !== 1'b1 && n < 40);
    endtask

    task automatic conclude();
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rdchk(irq_pkg::OFS_CONTROL, 32'h0);
        evt_in <= {3'h1, 8'h08, 8'h20};
        repeat (2) @(posedge ref_clk);
        evt_in <= '0;
        repeat (4) @(posedge ref_clk);
        rdchk(irq_pkg::OFS_CONTROL, 32'h01);
        rdchk(irq_pkg::OFS_PFLAG1, 32'h08);
        rdchk(irq_pkg::OFS_PFLAG2, 32'h20);
        bus(1'b1, irq_pkg::OFS_CONTROL, 8'h09);
        check("pending", 32'h0, irq_pending);
        bus(1'b1, irq_pkg::OFS_PFLAG2, 8'h00);
        bus(1'b1, irq_pkg::OFS_PEN1, 8'h08);
        bus(1'b1, irq_pkg::OFS_PEN2, 8'h01);
        bus(1'b1, irq_pkg::OFS_EVT_MSK, 8'h03);
        bus(1'b1, irq_pkg::OFS_CONTROL, 8'h88);
        check("pending", 32'h0, irq_pending);
        bus(1'b1, irq_pkg::OFS_CONTROL, 8'hC9);
        wait_vec();
        @(posedge ref_clk);
        check("pc", irq_pkg::VECTOR_ADDR, pc_in);
        rdchk(irq_pkg::OFS_CONTROL, 32'h49);
        // the model's context word follows the pc that was pushed
        ctx_exp = {stack_top[7:0], 24'h5A3CC3};
        rdchk(irq_pkg::OFS_SHADOW, ctx_exp);
        check("restore ctx", ctx_exp, core_cmd.restore_ctx);
        check("irq_out", 32'h1, irq_out);
        // a fresh event inside the handler must only set its flag
        bus(1'b1, irq_pkg::OFS_PFLAG1, 8'h00);
        evt_in <= {3'h0, 8'h08, 8'h00};
        @(posedge ref_clk);
        evt_in <= '0;
        repeat (2) @(posedge ref_clk);
        check("pending", 32'h0, irq_pending);
        rdchk(irq_pkg::OFS_PFLAG1, 32'h08);
        bus(1'b1, irq_pkg::OFS_EVT_MSK, 8'h00);
        @(posedge ref_clk);
        check("irq_out", 32'h0, irq_out);
        bus(1'b1, irq_pkg::OFS_EVT_ST, 8'h01);
        bus(1'b1, irq_pkg::OFS_EVT_MSK, 8'h03);
        @(posedge ref_clk);
        check("irq_out", 32'h0, irq_out);
        ret_pulse();
        wait_vec();
        check("retrigger", 32'h1, 32'(n < 8));
        rdchk(irq_pkg::OFS_PFLAG1, 32'h08);
        rdchk(irq_pkg::OFS_EVT_ST, 32'h03);
        bus(1'b1, irq_pkg::OFS_EVT_ST, 8'h03);
        bus(1'b1, irq_pkg::OFS_CONTROL, 8'h48);
        bus(1'b1, irq_pkg::OFS_PFLAG1, 8'h00);
        ret_pulse();
        repeat (3) @(posedge ref_clk);
        rdchk(irq_pkg::OFS_CONTROL, 32'hC8);
        rdchk(6'h3C, 32'h0);
        // sync source, sync source under stall, async source
        for (int i = 0; i < 3; i++) begin
            evt_in.core <= {2'b00, i != 2};
            evt_in.p2 <= {7'h00, i == 2};
            core_stall <= (i == 1);
            @(posedge ref_clk);
            evt_in <= '0;
            wait_vec();
            if (i == 2)
                check("latency", 32'h1, 32'(n >= 3 && n <= 5));
            else
                check("latency", 32'h1, 32'(n >= 3 && n <= 4));
            bus(1'b1, irq_pkg::OFS_CONTROL, 8'h48);
            bus(1'b1, irq_pkg::OFS_PFLAG2, 8'h00);
            ret_pulse();
            repeat (3) @(posedge ref_clk);
        end
        // a reset in mid-run must drop every enable again
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rdchk(irq_pkg::OFS_CONTROL, 32'h0);
        evt_in.core <= 3'h1;
        @(posedge ref_clk);
        evt_in <= '0;
        repeat (2) @(posedge ref_clk);
        check("pending", 32'h0, irq_pending);
        conclude();
    end
endmodule
